// ==== bench/sbfc_bridge_bench.sv ====
// Self-checking bench for the serial bridge with flow control
`timescale 1ns/100ps
module sbfc_bridge_bench;
   logic I_CLK = 1'b0;
   logic I_RST_N = 1'b1; // Pulled low just after time zero
   logic I_CFG_LOAD = 1'b0;
   sbfc_pkg::sbfc_cfg_t I_CFG = sbfc_pkg::CFG_RST;
   sbfc_pkg::sbfc_cfg_t O_CFG;
   logic I_VCOM_EN = 1'b1;
   logic I_TGT_TXD, O_TGT_RXD, O_TGT_CTS_N, O_TGT_CTS_OE, O_TX_BUSY;
   logic I_TGT_RTS_N = 1'b0;
   logic I_SOCK_CONN = 1'b0;
   sbfc_pkg::sbfc_byte_t I_SOCK_H2T = '0, I_USB_H2T = '0, O_SOCK_T2H, O_USB_T2H;
   logic O_SOCK_H2T_READY, O_USB_H2T_READY;
   logic I_SOCK_T2H_READY = 1'b0, I_USB_T2H_READY = 1'b0;
   logic cts_wire; // Resolved clear-to-send pin
   logic [7:0] rx_byte; // Last byte at the target
   int rx_cnt; // Bytes seen by the target
   int num_errors = 0, tests_run = 0, cyc = 0;
   // Pull-up holds the pin high when undriven
   assign cts_wire = O_TGT_CTS_OE ? O_TGT_CTS_N : 1'b1;
   sbfc_bridge DUT (.I_CLK(I_CLK), .I_RST_N(I_RST_N), .I_CFG_LOAD(I_CFG_LOAD),
      .I_CFG(I_CFG), .O_CFG(O_CFG), .I_VCOM_EN(I_VCOM_EN), .I_TGT_TXD(I_TGT_TXD),
      .O_TGT_RXD(O_TGT_RXD), .I_TGT_RTS_N(I_TGT_RTS_N), .O_TGT_CTS_N(O_TGT_CTS_N),
      .O_TGT_CTS_OE(O_TGT_CTS_OE), .I_SOCK_CONN(I_SOCK_CONN), .I_SOCK_H2T(I_SOCK_H2T),
      .O_SOCK_H2T_READY(O_SOCK_H2T_READY), .O_SOCK_T2H(O_SOCK_T2H),
      .I_SOCK_T2H_READY(I_SOCK_T2H_READY), .I_USB_H2T(I_USB_H2T),
      .O_USB_H2T_READY(O_USB_H2T_READY), .O_USB_T2H(O_USB_T2H),
      .I_USB_T2H_READY(I_USB_T2H_READY), .O_TX_BUSY(O_TX_BUSY));
   sbfc_tgt_model tgt (.i_clk(I_CLK), .i_rxd(O_TGT_RXD), .i_cts_n(cts_wire),
      .o_txd(I_TGT_TXD), .o_rx_byte(rx_byte), .o_rx_cnt(rx_cnt));
   // Clock generator
   initial forever #25 I_CLK = ~I_CLK;
   // Hang guard
   always @(posedge I_CLK) begin
      cyc++;
      if (cyc == 20000) begin
         num_errors++;
         report_and_stop();
      end
   end
   // Step past edges, then the drive offset
   task automatic tick(input int n = 1);
      repeat (n) @(posedge I_CLK);
      #5;
   endtask
   task automatic fail(input string m);
      num_errors++;
      $display("CHECK FAILED at %0t: %s", $time, m);
   endtask
   task automatic cmp_bit(input logic a, input logic e, input string m);
      tests_run++;
      if (a !== e) fail(m);
   endtask
   task automatic cmp_byte(input logic [7:0] a, input logic [7:0] e, input string m);
      tests_run++;
      if (a !== e) fail(m);
   endtask
   task automatic cmp_cfg(input sbfc_pkg::sbfc_cfg_t a, e, input string m);
      tests_run++;
      if (a !== e) fail(m);
   endtask
   // Load a configuration and check the clamped result
   task automatic load_cfg(input logic [1:0] m, input logic [11:0] d, e);
      I_CFG = '{mode: sbfc_pkg::sbfc_hs_t'(m), div: d};
      I_CFG_LOAD = 1'b1;
      tick();
      I_CFG_LOAD = 1'b0;
      tick(2);
      cmp_cfg(O_CFG, '{mode: sbfc_pkg::sbfc_hs_t'(m), div: e}, "config");
      tgt.div = e;
   endtask
   // Offer a host byte; expect it taken and seen whole at the target, or refused
   task automatic host_send(input bit sock, input logic [7:0] b, input bit ok, rts_up);
      int n;
      int c0;
      c0 = rx_cnt;
      n = 0;
      if (sock) I_SOCK_H2T = {1'b1, b};
      else I_USB_H2T = {1'b1, b};
      while ((sock ? O_SOCK_H2T_READY : O_USB_H2T_READY) !== 1'b1 && n < 100) begin
         tick();
         n++;
      end
      cmp_bit(n < 100, ok, "host byte acceptance");
      if (ok) tick();
      // Withdraw only the byte that was offered
      if (sock) I_SOCK_H2T = '0;
      else I_USB_H2T = '0;
      if (ok) begin
         // Start bit on the line one cycle after the take
         tick();
         cmp_bit(O_TX_BUSY, 1'b1, "frame in flight");
         cmp_bit(O_TGT_RXD, 1'b0, "start bit");
         if (rts_up) I_TGT_RTS_N = 1'b1;
         n = 0;
         while (rx_cnt == c0 && n < 12 * tgt.div) begin
            tick();
            n++;
         end
         cmp_bit(rx_cnt == c0 + 1, 1'b1, "frame at target");
         cmp_byte(rx_byte, b, "data at target");
      end
   endtask
   // Wait for a target byte on a host path, or check that none comes
   task automatic wait_t2h(input bit sock, input logic [7:0] b, input bit ok);
      int n;
      n = 0;
      tick();
      while ((sock ? O_SOCK_T2H.valid : O_USB_T2H.valid) !== 1'b1 && n < 3 * tgt.div) begin
         tick();
         n++;
      end
      cmp_bit(n < 3 * tgt.div, ok, "target byte arrival");
      if (ok) cmp_byte(sock ? O_SOCK_T2H.data : O_USB_T2H.data, b, "data at host");
   endtask
   // Consume the buffered byte; buffer free clears the stop request
   task automatic pop(input bit sock);
      if (sock) I_SOCK_T2H_READY = 1'b1;
      else I_USB_T2H_READY = 1'b1;
      tick();
      I_SOCK_T2H_READY = 1'b0;
      I_USB_T2H_READY = 1'b0;
      tick(2);
      cmp_bit(O_TGT_CTS_N, 1'b0, "clear after drain");
   endtask
   // All four handshake modes with request held off, then released
   task automatic mode_sweep();
      logic [1:0] m;
      for (int i = 0; i < 4; i++) begin
         m = 2'(i);
         load_cfg(m, sbfc_pkg::MIN_DIV, sbfc_pkg::MIN_DIV);
         cmp_bit(O_TGT_CTS_OE, m[0], "clear-to-send drive");
         I_TGT_RTS_N = 1'b1;
         tick(4);
         host_send(1'b0, 8'h50 + 8'(i), !m[1], 1'b0);
         I_TGT_RTS_N = 1'b0;
         tick(4);
         if (m[1]) host_send(1'b0, 8'h81, 1'b1, 1'b1);
         I_TGT_RTS_N = 1'b0;
         tick(4);
      end
   endtask
   // Full buffer stops a handshaking target until drained
   task automatic full_stall();
      load_cfg(2'h1, sbfc_pkg::MIN_DIV, sbfc_pkg::MIN_DIV);
      tgt.honor = 1'b1;
      tgt.send(8'h3C);
      wait_t2h(1'b0, 8'h3C, 1'b1);
      tick(2);
      cmp_bit(cts_wire, 1'b1, "full stops target");
      fork
         tgt.send(8'hC3);
         begin
            tick(100);
            cmp_bit(I_TGT_TXD, 1'b1, "target held");
            cmp_byte(O_USB_T2H.data, 8'h3C, "first byte kept");
            pop(1'b0);
         end
      join
      wait_t2h(1'b0, 8'hC3, 1'b1);
      pop(1'b0);
   endtask
   // Socket takes priority over the USB path
   task automatic socket_path();
      I_SOCK_CONN = 1'b1;
      tick(2);
      host_send(1'b0, 8'h11, 1'b0, 1'b0);
      host_send(1'b1, 8'h96, 1'b1, 1'b0);
      tgt.send(8'h69);
      wait_t2h(1'b1, 8'h69, 1'b1);
      cmp_bit(O_USB_T2H.valid, 1'b0, "usb silent");
      pop(1'b1);
      I_SOCK_CONN = 1'b0;
   endtask
   // Disabled path passes nothing either way
   task automatic enable_off();
      I_VCOM_EN = 1'b0;
      tick(4);
      host_send(1'b0, 8'h22, 1'b0, 1'b0);
      tgt.send(8'h44);
      wait_t2h(1'b0, 8'h44, 1'b0);
      I_VCOM_EN = 1'b1;
      tick(4);
   endtask
   task automatic report_and_stop();
      $display("Mismatches %0d, checks %0d", num_errors, tests_run);
      if (num_errors == 0 && tests_run > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask
   // Main sequence
   initial begin
      // Reset asserted as an edge so the async branches fire
      #1;
      I_RST_N = 1'b0;
      tick(20);
      I_RST_N = 1'b1;
      tick(6);
      cmp_cfg(O_CFG, sbfc_pkg::CFG_RST, "reset config");
      cmp_bit(O_TGT_CTS_OE, 1'b0, "reset drive");
      cmp_bit(O_TGT_RXD, 1'b1, "idle line");
      I_TGT_RTS_N = 1'b1;
      tick(4);
      host_send(1'b0, 8'hA5, 1'b1, 1'b0);
      tgt.send(8'h3C);
      wait_t2h(1'b0, 8'h3C, 1'b1);
      pop(1'b0);
      load_cfg(2'h0, 12'h00A, sbfc_pkg::MIN_DIV);
      load_cfg(2'h0, 12'hBB8, sbfc_pkg::MAX_DIV);
      mode_sweep();
      full_stall();
      socket_path();
      enable_off();
      report_and_stop();
   end
endmodule

// ==== bench/sbfc_tgt_model.sv ====
// Behavioural model of the target serial port with optional handshake
`timescale 1ns/100ps
module sbfc_tgt_model (
   input wire logic i_clk,
   input wire logic i_rxd,
   input wire logic i_cts_n,
   output logic o_txd,
   output logic [7:0] o_rx_byte,
   output int o_rx_cnt
);
   int div = sbfc_pkg::DEF_DIV; // Cycles per bit
   logic honor = 1'b0; // Wait for clear-to-send before a frame
   int k; // Receive bit index
   logic [7:0] sh; // Receive shift value
   initial o_txd = 1'b1;
   // Send one frame, holding off while clear-to-send is high
   task automatic send(input logic [7:0] b);
      int i;
      while (honor && i_cts_n !== 1'b0) @(posedge i_clk);
      for (i = 0; i < 10; i++) begin
         o_txd <= (i == 0) ? 1'b0 : (i == 9) ? 1'b1 : b[i-1];
         repeat (div) @(posedge i_clk);
      end
   endtask
   // Receiver: confirm start mid-bit, take bits LSB first, need high stop
   always begin
      @(negedge i_rxd);
      repeat (div / 2) @(posedge i_clk);
      if (i_rxd === 1'b0) begin
         for (k = 0; k < 8; k++) begin
            repeat (div) @(posedge i_clk);
            sh[k] = i_rxd;
         end
         repeat (div) @(posedge i_clk);
         if (i_rxd === 1'b1) begin
            o_rx_byte = sh;
            o_rx_cnt++;
         end
      end
   end
endmodule

// ==== logic/sbfc_bridge.sv ====
// Bridge between target serial line and two host byte streams
// Operation
// R1 - Reset: 115200 8N1, handshake lines ignored
// R2 - Bit rate configurable 9600 to 921600
// R3 - Full receive buffer deasserts driven clear-to-send
// R4 - Target stops sending while clear-to-send deasserted
// R5 - Honoured request-to-send low pauses sending; code pauses while the pin is high
// R6 - Character in flight always completes
// R7 - Request-to-send ignored when not honoured
// R8 - Off mode: no drive, request ignored
// R9 - Drive mode: drive clear, ignore request
// R10 - Honour mode: no drive, gate on request
// R11 - Both mode: drive clear and gate
// R12 - Socket connection takes all traffic over USB
// R13 - Forward both directions on active path
// R14 - Target drives request when honoured
// R15 - Pass data only while enable active
// R16 - Low start, LSB first, high stop, idle high
`timescale 1ns/100ps
module sbfc_bridge (
   input wire logic I_CLK,
   input wire logic I_RST_N,
   input wire logic I_CFG_LOAD,
   input wire sbfc_pkg::sbfc_cfg_t I_CFG,
   output sbfc_pkg::sbfc_cfg_t O_CFG,
   input wire logic I_VCOM_EN,
   input wire logic I_TGT_TXD,
   output logic O_TGT_RXD,
   input wire logic I_TGT_RTS_N,
   output logic O_TGT_CTS_N,
   output logic O_TGT_CTS_OE,
   input wire logic I_SOCK_CONN,
   input wire sbfc_pkg::sbfc_byte_t I_SOCK_H2T,
   output logic O_SOCK_H2T_READY,
   output sbfc_pkg::sbfc_byte_t O_SOCK_T2H,
   input wire logic I_SOCK_T2H_READY,
   input wire sbfc_pkg::sbfc_byte_t I_USB_H2T,
   output logic O_USB_H2T_READY,
   output sbfc_pkg::sbfc_byte_t O_USB_T2H,
   input wire logic I_USB_T2H_READY,
   output logic O_TX_BUSY
);
   localparam int DW = sbfc_pkg::DIV_W;

   // Receiver states
   typedef enum logic [1:0] {
      RX_IDLE  = 2'h0,
      RX_START = 2'h1,
      RX_DATA  = 2'h2,
      RX_STOP  = 2'h3
   } sbfc_rx_t;

   // Keep a requested divisor inside the supported rate range
   function automatic logic [11:0] clamp_div(input logic [11:0] d);
      if (d < sbfc_pkg::MIN_DIV) begin
         return sbfc_pkg::MIN_DIV;
      end else if (d > sbfc_pkg::MAX_DIV) begin
         return sbfc_pkg::MAX_DIV;
      end
      return d;
   endfunction

   logic rst_meta_ff; // Reset release, first stage
   logic rst_n_ff; // Reset release, used copy
   logic [2:0] pin_meta_ff; // Pin synchroniser, first stage
   logic [2:0] pin_ff; // Pin synchroniser, second stage
   sbfc_pkg::sbfc_cfg_t cfg_ff; // Active configuration
   sbfc_rx_t rx_st_ff; // Receiver state
   logic [DW-1:0] rx_cnt_ff; // Receiver cycle count
   logic [2:0] rx_bit_ff; // Data bit index
   logic [7:0] rx_shf_ff; // Receive shift register
   logic rx_done_ff; // One-cycle pulse, character in
   sbfc_pkg::sbfc_byte_t sock_t2h_ff; // Buffered char for socket
   sbfc_pkg::sbfc_byte_t usb_t2h_ff; // Buffered char for USB
   logic sock_rdy_ff; // Socket may hand a byte
   logic usb_rdy_ff; // USB may hand a byte
   logic tx_start_ff; // Start pulse to transmitter
   logic [7:0] tx_data_ff; // Byte to transmit
   logic cts_n_ff; // Clear-to-send level, low means clear
   logic cts_oe_ff; // Clear-to-send driven
   logic tx_busy; // Transmitter in a frame

   // Synchronised pin levels
   wire rxd = pin_ff[0];
   wire rts_n = pin_ff[1];
   wire vcom_en = pin_ff[2];

   // Handshake decode
   wire drive_cts = cfg_ff.mode[0]; // R9 R11
   wire honor_rts = cfg_ff.mode[1]; // R10 R11
   wire permit = !honor_rts || !rts_n; // R7
   wire t2h_full = sock_t2h_ff.valid || usb_t2h_ff.valid;
   wire can_take = vcom_en && permit && !tx_busy && !tx_start_ff; // R15
   wire take_sock = sock_rdy_ff && I_SOCK_H2T.valid;
   wire take_usb = usb_rdy_ff && I_USB_H2T.valid;
   wire take = take_sock || take_usb;

   // Receiver timing decode
   wire rx_half = rx_cnt_ff == (cfg_ff.div >> 1);
   wire rx_end = rx_cnt_ff == cfg_ff.div - 1'b1;
   wire [DW-1:0] nxt_rx_cnt = rx_end ? '0 : rx_cnt_ff + 1'b1;
   wire rx_keep = rx_done_ff && !t2h_full;

   assign O_CFG = cfg_ff;
   assign O_TGT_CTS_N = cts_n_ff;
   assign O_TGT_CTS_OE = cts_oe_ff;
   assign O_SOCK_T2H = sock_t2h_ff;
   assign O_USB_T2H = usb_t2h_ff;
   assign O_SOCK_H2T_READY = sock_rdy_ff;
   assign O_USB_H2T_READY = usb_rdy_ff;
   assign O_TX_BUSY = tx_busy;

   // Reset release through two flops
   always_ff @(posedge I_CLK or negedge I_RST_N) begin
      if (!I_RST_N) begin
         rst_meta_ff <= 1'b0;
         rst_n_ff <= 1'b0;
      end else begin
         rst_meta_ff <= 1'b1;
         rst_n_ff <= rst_meta_ff;
      end
   end

   // Pin inputs through two flops
   always_ff @(posedge I_CLK or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         pin_meta_ff <= sbfc_pkg::SYNC_RST;
         pin_ff <= sbfc_pkg::SYNC_RST;
      end else begin
         pin_meta_ff <= {I_VCOM_EN, I_TGT_RTS_N, I_TGT_TXD};
         pin_ff <= pin_meta_ff;
      end
   end

   // Configuration load with range clamp
   always_ff @(posedge I_CLK or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         cfg_ff <= sbfc_pkg::CFG_RST; // R1
      end else if (I_CFG_LOAD) begin
         cfg_ff <= '{mode: I_CFG.mode, div: clamp_div(I_CFG.div)}; // R2
      end
   end

   // Receiver: mid-bit sampling, stop bit checked
   always_ff @(posedge I_CLK or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         rx_st_ff <= RX_IDLE;
         rx_cnt_ff <= '0;
         rx_bit_ff <= 3'h0;
         rx_shf_ff <= 8'h00;
         rx_done_ff <= 1'b0;
      end else begin
         rx_done_ff <= 1'b0;
         rx_cnt_ff <= nxt_rx_cnt;
         case (rx_st_ff)
            RX_IDLE: begin
               // Low line level opens a frame
               rx_cnt_ff <= '0;
               if (vcom_en && !rxd) begin
                  rx_st_ff <= RX_START; // R15
               end
            end
            RX_START: begin
               // Confirm start at its middle
               if (rx_half) begin
                  rx_cnt_ff <= '0;
                  rx_bit_ff <= 3'h0;
                  rx_st_ff <= rxd ? RX_IDLE : RX_DATA; // R16
               end
            end
            RX_DATA: begin
               // LSB arrives first
               if (rx_end) begin
                  rx_shf_ff <= {rxd, rx_shf_ff[7:1]}; // R16
                  rx_bit_ff <= rx_bit_ff + 3'h1;
                  if (rx_bit_ff == sbfc_pkg::LAST_DATA) begin
                     rx_st_ff <= RX_STOP;
                  end
               end
            end
            RX_STOP: begin
               // Good stop bit delivers, bad one drops
               if (rx_end) begin
                  rx_done_ff <= rxd; // R16
                  rx_st_ff <= RX_IDLE;
               end
            end
            default: begin
               rx_st_ff <= RX_IDLE;
            end
         endcase
         if (!vcom_en) begin
            rx_st_ff <= RX_IDLE; // R15
         end
      end
   end

   // One-char buffers toward the host paths, socket first
   always_ff @(posedge I_CLK or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         sock_t2h_ff <= '0;
         usb_t2h_ff <= '0;
      end else begin
         if (!I_SOCK_CONN) begin
            sock_t2h_ff.valid <= 1'b0; // R12
         end else if (rx_keep) begin
            sock_t2h_ff <= '{valid: 1'b1, data: rx_shf_ff}; // R13
         end else if (I_SOCK_T2H_READY) begin
            sock_t2h_ff.valid <= 1'b0;
         end
         if (I_SOCK_CONN) begin
            usb_t2h_ff.valid <= 1'b0; // R12
         end else if (rx_keep) begin
            usb_t2h_ff <= '{valid: 1'b1, data: rx_shf_ff}; // R13
         end else if (I_USB_T2H_READY) begin
            usb_t2h_ff.valid <= 1'b0;
         end
      end
   end

   // Host-to-target acceptance, gated by handshake and path choice
   always_ff @(posedge I_CLK or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         sock_rdy_ff <= 1'b0;
         usb_rdy_ff <= 1'b0;
         tx_start_ff <= 1'b0;
         tx_data_ff <= 8'h00;
      end else begin
         sock_rdy_ff <= I_SOCK_CONN && can_take && !take; // R5
         usb_rdy_ff <= !I_SOCK_CONN && can_take && !take; // R12
         tx_start_ff <= take; // R13
         if (take) begin
            tx_data_ff <= take_sock ? I_SOCK_H2T.data : I_USB_H2T.data;
         end
      end
   end

   // Clear-to-send: deasserted when buffer full, released when not driven
   always_ff @(posedge I_CLK or negedge rst_n_ff) begin
      if (!rst_n_ff) begin
         cts_n_ff <= 1'b0;
         cts_oe_ff <= 1'b0;
      end else begin
         cts_n_ff <= t2h_full; // R3
         cts_oe_ff <= drive_cts; // R8
      end
   end

   // Transmitter toward the target
   sbfc_uart_tx #(.DIV_W(DW)) u_tx (
      .i_clk(I_CLK),
      .i_rst_n(rst_n_ff),
      .i_div(cfg_ff.div),
      .i_start(tx_start_ff),
      .i_data(tx_data_ff),
      .o_txd(O_TGT_RXD),
      .o_busy(tx_busy)
   );

   default clocking cb @(posedge I_CLK); endclocking
   default disable iff (!rst_n_ff);

   property p_reset_cfg;
      $past(!rst_n_ff) |-> cfg_ff == sbfc_pkg::CFG_RST;
   endproperty
   a_reset_cfg: assert property (p_reset_cfg) else $error("bad reset config"); // R1

   property p_div_range;
      cfg_ff.div >= sbfc_pkg::MIN_DIV && cfg_ff.div <= sbfc_pkg::MAX_DIV;
   endproperty
   a_div_range: assert property (p_div_range) else $error("divisor out of range"); // R2

   property p_cts_full;
      drive_cts && t2h_full |=> O_TGT_CTS_N && O_TGT_CTS_OE;
   endproperty
   a_cts_full: assert property (p_cts_full) else $error("cts not deasserted"); // R3

   property p_rts_pause;
      honor_rts && rts_n |=> !O_SOCK_H2T_READY && !O_USB_H2T_READY;
   endproperty
   a_rts_pause: assert property (p_rts_pause) else $error("sent while paused"); // R5

   property p_no_drive;
      !drive_cts |=> !O_TGT_CTS_OE;
   endproperty
   a_no_drive: assert property (p_no_drive) else $error("cts driven"); // R8

   property p_sock_prio;
      I_SOCK_CONN |=> !O_USB_H2T_READY && !O_USB_T2H.valid;
   endproperty
   a_sock_prio: assert property (p_sock_prio) else $error("usb active with socket"); // R12

   property p_forward;
      rx_keep && I_SOCK_CONN |=> O_SOCK_T2H.valid && O_SOCK_T2H.data == $past(rx_shf_ff);
   endproperty
   a_forward: assert property (p_forward) else $error("char not forwarded"); // R13

   property p_enable;
      !vcom_en |=> rx_st_ff == RX_IDLE && !O_SOCK_H2T_READY && !O_USB_H2T_READY;
   endproperty
   a_enable: assert property (p_enable) else $error("traffic while disabled"); // R15

   c_rx_char: cover property (rx_done_ff);
   c_sock_tx: cover property (take_sock);
   c_usb_tx: cover property (take_usb);
   c_cts_held: cover property (O_TGT_CTS_OE && O_TGT_CTS_N);
endmodule

// ==== logic/sbfc_pkg.sv ====
// Shared constants and types for the serial bridge with flow control
package sbfc_pkg;
   // System clock rate in Hz
   localparam int CLK_HZ = 20_000_000;
   // Bit rates in bits per second
   localparam int DEF_BAUD = 115200;
   localparam int MIN_BAUD = 9600;
   localparam int MAX_BAUD = 921600;
   // Width of the cycles-per-bit divisor
   localparam int DIV_W = 12;
   // Cycles per bit, rounded to nearest
   localparam logic [11:0] DEF_DIV = 12'((CLK_HZ + DEF_BAUD / 2) / DEF_BAUD);
   localparam logic [11:0] MIN_DIV = 12'((CLK_HZ + MAX_BAUD / 2) / MAX_BAUD);
   localparam logic [11:0] MAX_DIV = 12'((CLK_HZ + MIN_BAUD / 2) / MIN_BAUD);
   // Bit slot index of the stop bit within a frame
   localparam logic [3:0] STOP_IDX = 4'h9;
   // Index of the last data bit
   localparam logic [2:0] LAST_DATA = 3'h7;
   // Synchroniser reset value: enable low, request idle high, line idle high
   localparam logic [2:0] SYNC_RST = 3'h3;
   // Handshake modes: bit 0 drives clear-to-send, bit 1 honours request-to-send
   typedef enum logic [1:0] {
      HS_OFF   = 2'h0,
      HS_DRIVE = 2'h1,
      HS_HONOR = 2'h2,
      HS_BOTH  = 2'h3
   } sbfc_hs_t;
   // One byte of a stream with its valid flag
   typedef struct packed {
      logic valid;
      logic [7:0] data;
   } sbfc_byte_t;
   // Serial configuration
   typedef struct packed {
      sbfc_hs_t mode;
      logic [11:0] div;
   } sbfc_cfg_t;
   // Configuration after reset: default rate, handshake ignored
   localparam sbfc_cfg_t CFG_RST = '{mode: HS_OFF, div: DEF_DIV};
endpackage

// ==== logic/sbfc_uart_tx.sv ====
// Serial transmitter toward the target, one character per start
`timescale 1ns/100ps
module sbfc_uart_tx #(
   parameter int DIV_W = 12
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic [DIV_W-1:0] i_div,
   input wire logic i_start,
   input wire logic [7:0] i_data,
   output logic o_txd,
   output logic o_busy
);
   logic [DIV_W-1:0] cnt_ff; // Cycle count within a bit
   logic [3:0] bit_ff; // Bit slot, 0 start, 9 stop
   logic [8:0] frame_ff; // Data still to go, ones fill the top
   logic txd_ff; // Line level
   logic busy_ff; // Character in flight
   wire tick = busy_ff && (cnt_ff == i_div - 1'b1); // End of a bit slot
   wire last = bit_ff == sbfc_pkg::STOP_IDX; // Stop bit slot
   wire [DIV_W-1:0] nxt_cnt = tick ? '0 : cnt_ff + 1'b1;

   assign o_txd = txd_ff;
   assign o_busy = busy_ff;

   // Shift out start, eight data bits LSB first, then stop
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         cnt_ff <= '0;
         bit_ff <= 4'h0;
         frame_ff <= 9'h1FF;
         txd_ff <= 1'b1;
         busy_ff <= 1'b0;
      end else if (!busy_ff) begin
         // Idle line high until a start
         txd_ff <= !i_start; // R16
         busy_ff <= i_start;
         frame_ff <= {1'b1, i_data};
         cnt_ff <= '0;
         bit_ff <= 4'h0;
      end else begin
         // Request-to-send is not looked at here: a frame always completes
         cnt_ff <= nxt_cnt; // R6
         if (tick && last) begin
            busy_ff <= 1'b0;
            txd_ff <= 1'b1;
         end else if (tick) begin
            txd_ff <= frame_ff[0]; // R16
            frame_ff <= {1'b1, frame_ff[8:1]};
            bit_ff <= bit_ff + 4'h1;
         end
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (!i_rst_n);

   // Start bit goes low right after a start
   property p_start_low;
      !busy_ff && i_start |=> !txd_ff && busy_ff;
   endproperty
   a_start_low: assert property (p_start_low) else $error("start bit not low"); // R16

   // Stop slot is high
   property p_stop_high;
      busy_ff && last |-> txd_ff;
   endproperty
   a_stop_high: assert property (p_stop_high) else $error("stop bit not high"); // R16

   // A frame only ends after its stop slot
   property p_no_abort;
      $fell(busy_ff) |-> $past(bit_ff) == sbfc_pkg::STOP_IDX;
   endproperty
   a_no_abort: assert property (p_no_abort) else $error("frame cut short"); // R6

   c_frame_done: cover property ($fell(busy_ff));
endmodule
